// ===== common/editor_pkg.sv
// constants, types and helpers for the keypad register editor
package editor_pkg;

    // ****************
    // sizes
    // ****************
    localparam int MENU_W = 2;
    localparam int IDX_W = 5;
    localparam int ADDR_W = MENU_W + IDX_W;
    localparam int DIGITS = 4;
    localparam int VALUE_W = 4 * DIGITS;
    localparam int DEPTH = 1 << ADDR_W;

    // ****************
    // submenus
    // ****************
    localparam logic [MENU_W-1:0] MENU_DATA_IN = 2'h0;
    localparam logic [MENU_W-1:0] MENU_SETUP = 2'h1;
    localparam logic [MENU_W-1:0] MENU_ADJUST = 2'h2;
    localparam logic [MENU_W-1:0] MENU_TEST = 2'h3;
    localparam logic [MENU_W-1:0] MENU_LAST = 2'h3;
    localparam logic [IDX_W-1:0] COUNT_DATA_IN = 5'h1F;
    localparam logic [IDX_W-1:0] COUNT_SETUP = 5'h12;
    localparam logic [IDX_W-1:0] COUNT_ADJUST = 5'h02;
    localparam logic [IDX_W-1:0] COUNT_TEST = 5'h0E;

    // ****************
    // display kinds and codes
    // ****************
    localparam logic [1:0] SHOW_VERSION = 2'h0;
    localparam logic [1:0] SHOW_TITLE = 2'h1;
    localparam logic [1:0] SHOW_NAME = 2'h2;
    localparam logic [1:0] SHOW_VALUE = 2'h3;
    localparam logic [7:0] ACCESS_LETTER = 8'h43;
    localparam logic [1:0] CURSOR_LEFT = 2'h0;
    localparam logic [1:0] CURSOR_RIGHT = 2'h3;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [IDX_W-1:0] TEN = 5'h0A;

    typedef enum {ST_RUN, ST_MENU, ST_NAME, ST_LOAD, ST_EDIT, ST_COMMIT} edit_state_e;

    function automatic logic [IDX_W-1:0] reg_count(input logic [MENU_W-1:0] menu);
        case (menu)
            MENU_DATA_IN: reg_count = COUNT_DATA_IN;
            MENU_SETUP: reg_count = COUNT_SETUP;
            MENU_ADJUST: reg_count = COUNT_ADJUST;
            default: reg_count = COUNT_TEST;
        endcase
    endfunction

    function automatic logic [IDX_W-1:0] idx_step(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] count,
                                                  input logic up);
        if (up) begin
            idx_step = (idx == count - 5'h01) ? 5'h00 : idx + 5'h01;
        end else begin
            idx_step = (idx == 5'h00) ? count - 5'h01 : idx - 5'h01;
        end
    endfunction

endpackage

// ===== common/store_if.sv
// carrier between the editor and its parameter store
`timescale 1ns/100ps
interface store_if;
    import editor_pkg::*;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [VALUE_W-1:0] wr_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [VALUE_W-1:0] rd_data;
    modport editor (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface // store_if

// ===== core/param_store.sv
// parameter store memory with registered read data
`timescale 1ns/100ps
module param_store import editor_pkg::*; (
    // clock
    input wire logic ref_clk,
    // access
    store_if.store port
);

    // ****************
    // storage
    // ****************
    logic [VALUE_W-1:0] mem [DEPTH];
    logic [VALUE_W-1:0] rd_data_reg;

    always_ff @(posedge ref_clk) begin
        if (port.wr_en) begin
            mem[port.wr_addr] <= port.wr_data;
        end
        rd_data_reg <= mem[port.rd_addr];
    end

    assign port.rd_data = rd_data_reg;

endmodule // param_store

// ===== core/keypad_register_editor.sv
// keypad and display register editor gated by the run/programming switch
`timescale 1ns/100ps
// Function
// - run shows version, buttons ignored
// - keypad edits in programming, serial in run
// - programming stops machine and serial
// - four submenus offered
// - increment button: next register, menu, digit
// - decrement button: previous register, menu, digit
// - shift button: back to titles, cursor right
// - enter button: descend, open value, store
// - entering submenu shows first register name
// - opened register shows value, cursor leftmost
// - commit stores, then shows next register
// - back to run shows version, ready
// - each register has letter plus two-digit code
module keypad_register_editor import editor_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // operator controls
    input wire logic programming_switch_position,
    input wire logic btn_increment,
    input wire logic btn_decrement,
    input wire logic btn_shift,
    input wire logic btn_enter,
    // serial parameter writes
    input wire logic ser_wr_valid,
    input wire logic [ADDR_W-1:0] ser_wr_addr,
    input wire logic [VALUE_W-1:0] ser_wr_data,
    output logic ser_wr_ack,
    // machine status
    output logic machine_run_enable,
    output logic serial_enable,
    output logic ready,
    // non-volatile store
    output logic nv_store,
    output logic [ADDR_W-1:0] nv_addr,
    output logic [VALUE_W-1:0] nv_data,
    // display
    output logic [1:0] disp_kind,
    output logic [MENU_W-1:0] disp_menu,
    output logic [7:0] disp_code_letter,
    output logic [3:0] disp_code_tens,
    output logic [3:0] disp_code_ones,
    output logic [VALUE_W-1:0] disp_value,
    output logic [1:0] disp_cursor
);

    // ****************
    // helpers
    // ****************
    function automatic logic [VALUE_W-1:0] digit_step(input logic [VALUE_W-1:0] value, input logic [1:0] cursor,
                                                      input logic up);
        logic [VALUE_W-1:0] result;
        logic [3:0] digit;
        logic [1:0] pos;
        result = value;
        pos = CURSOR_RIGHT - cursor;
        digit = value[pos*4 +: 4];
        if (up) begin
            digit = (digit >= DIGIT_MAX) ? 4'h0 : digit + 4'h1;
        end else begin
            digit = (digit == 4'h0 || digit > DIGIT_MAX) ? DIGIT_MAX : digit - 4'h1;
        end
        result[pos*4 +: 4] = digit;
        return result;
    endfunction

    // ****************
    // button edges
    // ****************
    logic [3:0] btn_prev_reg;
    logic [3:0] btn_prev_next;
    logic [3:0] btn_now;
    logic press_inc;
    logic press_dec;
    logic press_shift;
    logic press_enter;

    always_comb begin
        btn_now = {btn_enter, btn_shift, btn_decrement, btn_increment};
        btn_prev_next = btn_now;
        press_inc = btn_now[0] & ~btn_prev_reg[0];
        press_dec = btn_now[1] & ~btn_prev_reg[1];
        press_shift = btn_now[2] & ~btn_prev_reg[2];
        press_enter = btn_now[3] & ~btn_prev_reg[3];
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            btn_prev_reg <= 4'h0;
        end else begin
            btn_prev_reg <= btn_prev_next;
        end
    end

    // ****************
    // editor state
    // ****************
    edit_state_e state_reg;
    edit_state_e state_next;
    logic [MENU_W-1:0] menu_reg;
    logic [MENU_W-1:0] menu_next;
    logic [IDX_W-1:0] idx_reg;
    logic [IDX_W-1:0] idx_next;
    logic [VALUE_W-1:0] value_reg;
    logic [VALUE_W-1:0] value_next;
    logic [1:0] cursor_reg;
    logic [1:0] cursor_next;
    logic [IDX_W-1:0] count;

    store_if store ();

    param_store u_store (
        .ref_clk(ref_clk),
        .port(store.store)
    );

    always_comb begin
        state_next = state_reg;
        menu_next = menu_reg;
        idx_next = idx_reg;
        value_next = value_reg;
        cursor_next = cursor_reg;
        count = reg_count(menu_reg);
        case (state_reg)
            ST_RUN: begin
                if (programming_switch_position) begin
                    state_next = ST_MENU;
                    menu_next = MENU_DATA_IN;
                end
            end
            ST_MENU: begin
                if (press_enter) begin
                    state_next = ST_NAME;
                    idx_next = 5'h00;
                end else if (press_inc) begin
                    menu_next = (menu_reg == MENU_LAST) ? MENU_DATA_IN : menu_reg + 2'h1;
                end else if (press_dec) begin
                    menu_next = (menu_reg == MENU_DATA_IN) ? MENU_LAST : menu_reg - 2'h1;
                end
            end
            ST_NAME: begin
                if (press_enter) begin
                    state_next = ST_LOAD;
                end else if (press_shift) begin
                    state_next = ST_MENU;
                end else if (press_inc) begin
                    idx_next = idx_step(idx_reg, count, 1'b1);
                end else if (press_dec) begin
                    idx_next = idx_step(idx_reg, count, 1'b0);
                end
            end
            ST_LOAD: begin
                value_next = store.rd_data;
                cursor_next = CURSOR_LEFT;
                state_next = ST_EDIT;
            end
            ST_EDIT: begin
                if (press_enter) begin
                    state_next = ST_COMMIT;
                end else if (press_shift) begin
                    cursor_next = (cursor_reg == CURSOR_RIGHT) ? CURSOR_LEFT : cursor_reg + 2'h1;
                end else if (press_inc) begin
                    value_next = digit_step(value_reg, cursor_reg, 1'b1);
                end else if (press_dec) begin
                    value_next = digit_step(value_reg, cursor_reg, 1'b0);
                end
            end
            ST_COMMIT: begin
                idx_next = idx_step(idx_reg, count, 1'b1);
                state_next = ST_NAME;
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
        if (!programming_switch_position) begin
            state_next = ST_RUN;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg <= ST_RUN;
            menu_reg <= MENU_DATA_IN;
            idx_reg <= 5'h00;
            value_reg <= 16'h0000;
            cursor_reg <= CURSOR_LEFT;
        end else begin
            state_reg <= state_next;
            menu_reg <= menu_next;
            idx_reg <= idx_next;
            value_reg <= value_next;
            cursor_reg <= cursor_next;
        end
    end

    // ****************
    // store access
    // ****************
    logic ser_take;

    always_comb begin
        ser_take = ser_wr_valid && state_reg == ST_RUN && !programming_switch_position;
        store.rd_addr = {menu_reg, idx_reg};
        // commit writes the store, only while programming
        if (state_reg == ST_COMMIT && programming_switch_position) begin
            store.wr_en = 1'b1;
            store.wr_addr = {menu_reg, idx_reg};
            store.wr_data = value_reg;
        end else begin
            store.wr_en = ser_take;
            store.wr_addr = ser_wr_addr;
            store.wr_data = ser_wr_data;
        end
    end

    // ****************
    // registered outputs
    // ****************
    logic ser_wr_ack_next;
    logic machine_run_enable_next;
    logic serial_enable_next;
    logic ready_next;
    logic nv_store_next;
    logic [ADDR_W-1:0] nv_addr_next;
    logic [VALUE_W-1:0] nv_data_next;
    logic [1:0] disp_kind_next;
    logic [3:0] code_tens_next;
    logic [3:0] code_ones_next;
    logic [VALUE_W-1:0] disp_value_next;
    logic [IDX_W-1:0] tens_idx;

    always_comb begin
        ser_wr_ack_next = ser_take;
        machine_run_enable_next = state_next == ST_RUN;
        serial_enable_next = state_next == ST_RUN;
        ready_next = state_next == ST_RUN;
        // a commit cut by the switch is discarded
        nv_store_next = state_reg == ST_COMMIT && programming_switch_position;
        nv_addr_next = nv_store_next ? {menu_reg, idx_reg} : nv_addr;
        nv_data_next = nv_store_next ? value_reg : nv_data;
        disp_value_next = value_next;
        case (state_next)
            ST_RUN: disp_kind_next = SHOW_VERSION;
            ST_MENU: disp_kind_next = SHOW_TITLE;
            ST_EDIT: disp_kind_next = SHOW_VALUE;
            default: disp_kind_next = SHOW_NAME;
        endcase
        if (state_next == ST_LOAD) begin
            disp_value_next = store.rd_data;
        end
        tens_idx = 5'h00;
        code_tens_next = 4'h0;
        for (int i = 1; i <= 3; i++) begin
            if (idx_next >= TEN * i[IDX_W-1:0]) begin
                code_tens_next = i[3:0];
                tens_idx = TEN * i[IDX_W-1:0];
            end
        end
        code_ones_next = 4'(idx_next - tens_idx);
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ser_wr_ack <= 1'b0;
            machine_run_enable <= 1'b1;
            serial_enable <= 1'b1;
            ready <= 1'b1;
            nv_store <= 1'b0;
            nv_addr <= 7'h00;
            nv_data <= 16'h0000;
            disp_kind <= SHOW_VERSION;
            disp_menu <= MENU_DATA_IN;
            disp_code_letter <= ACCESS_LETTER;
            disp_code_tens <= 4'h0;
            disp_code_ones <= 4'h0;
            disp_value <= 16'h0000;
            disp_cursor <= CURSOR_LEFT;
        end else begin
            ser_wr_ack <= ser_wr_ack_next;
            machine_run_enable <= machine_run_enable_next;
            serial_enable <= serial_enable_next;
            ready <= ready_next;
            nv_store <= nv_store_next;
            nv_addr <= nv_addr_next;
            nv_data <= nv_data_next;
            disp_kind <= disp_kind_next;
            disp_menu <= menu_next;
            disp_code_letter <= ACCESS_LETTER;
            disp_code_tens <= code_tens_next;
            disp_code_ones <= code_ones_next;
            disp_value <= disp_value_next;
            disp_cursor <= cursor_next;
        end
    end

endmodule // keypad_register_editor

// ===== verification/editor_checker.sv
// concurrent checks on the keypad register editor ports
`timescale 1ns/100ps
module editor_checker import editor_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // controls
    input wire logic programming_switch_position,
    input wire logic ser_wr_valid,
    // status
    input wire logic ser_wr_ack,
    input wire logic machine_run_enable,
    input wire logic serial_enable,
    input wire logic ready,
    input wire logic nv_store,
    // display
    input wire logic [1:0] disp_kind,
    input wire logic [7:0] disp_code_letter,
    input wire logic [3:0] disp_code_ones
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // ****************
    // properties
    // ****************
    a_run_version: assert property (
        !programming_switch_position |=> disp_kind == SHOW_VERSION) else $error("version not shown in run");
    a_run_status: assert property (
        !programming_switch_position |=> machine_run_enable && serial_enable && ready) else $error("run status low");
    a_prog_stops: assert property (
        programming_switch_position |=> !machine_run_enable && !serial_enable && !ready) else $error("machine on");
    a_prog_no_ack: assert property (
        programming_switch_position |=> !ser_wr_ack) else $error("serial ack in programming");
    a_serial_ack: assert property (
        ser_wr_valid && serial_enable && !programming_switch_position |=> ser_wr_ack) else $error("serial not acked");
    a_ack_cause: assert property (
        ser_wr_ack |-> $past(ser_wr_valid) && !$past(programming_switch_position)) else $error("ack without cause");
    a_store_once: assert property (
        nv_store |-> $past(programming_switch_position) && !$past(nv_store)) else $error("bad store pulse");
    a_access_code: assert property (
        disp_code_letter == ACCESS_LETTER && disp_code_ones <= DIGIT_MAX) else $error("bad access code");
    a_prog_title: assert property (
        $rose(programming_switch_position) |=> disp_kind == SHOW_TITLE) else $error("no title on programming");
endmodule // editor_checker

bind keypad_register_editor editor_checker i_editor_checker (.ref_clk(ref_clk), .reset(reset),
    .programming_switch_position(programming_switch_position), .ser_wr_valid(ser_wr_valid),
    .ser_wr_ack(ser_wr_ack), .machine_run_enable(machine_run_enable), .serial_enable(serial_enable),
    .ready(ready), .nv_store(nv_store), .disp_kind(disp_kind), .disp_code_letter(disp_code_letter),
    .disp_code_ones(disp_code_ones));

// ===== verification/key_operator.sv
// operator model pressing the four keypad buttons
`timescale 1ns/100ps
module key_operator (
    // clock
    input wire logic ref_clk,
    // buttons
    output logic btn_increment,
    output logic btn_decrement,
    output logic btn_shift,
    output logic btn_enter
);
    initial begin
        {btn_increment, btn_decrement, btn_shift, btn_enter} = 4'h0;
    end

    // one press: high one cycle, then released long enough for load
    task automatic press(input logic [1:0] which);
        @(negedge ref_clk);
        case (which)
            2'h0: btn_increment = 1'b1;
            2'h1: btn_decrement = 1'b1;
            2'h2: btn_shift = 1'b1;
            default: btn_enter = 1'b1;
        endcase
        @(negedge ref_clk);
        {btn_increment, btn_decrement, btn_shift, btn_enter} = 4'h0;
        repeat (4) @(negedge ref_clk);
    endtask
endmodule // key_operator

// ===== verification/keypad_register_editor_tb.sv
// self-checking bench for the keypad register editor
`timescale 1ns/100ps
module keypad_register_editor_tb;
    import editor_pkg::*;
    localparam logic [1:0] INC = 2'h0;
    localparam logic [1:0] DEC = 2'h1;
    localparam logic [1:0] SHF = 2'h2;
    localparam logic [1:0] ENT = 2'h3;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic programming_switch_position = 1'b0;
    logic ser_wr_valid = 1'b0;
    logic [ADDR_W-1:0] ser_wr_addr = 7'h00;
    logic [VALUE_W-1:0] ser_wr_data = 16'h0000;
    logic btn_increment, btn_decrement, btn_shift, btn_enter;
    logic ser_wr_ack, machine_run_enable, serial_enable, ready, nv_store;
    logic [ADDR_W-1:0] nv_addr;
    logic [VALUE_W-1:0] nv_data;
    logic [1:0] disp_kind;
    logic [MENU_W-1:0] disp_menu;
    logic [7:0] disp_code_letter;
    logic [3:0] disp_code_tens, disp_code_ones;
    logic [VALUE_W-1:0] disp_value;
    logic [1:0] disp_cursor;
    int num_errors = 0;
    int n_compared = 0;
    int acks = 0;
    int stores = 0;
    logic [ADDR_W-1:0] st_addr;
    logic [VALUE_W-1:0] st_data;

    always #20 ref_clk = ~ref_clk;

    keypad_register_editor i_keypad_register_editor (.ref_clk(ref_clk), .reset(reset),
        .programming_switch_position(programming_switch_position), .btn_increment(btn_increment),
        .btn_decrement(btn_decrement), .btn_shift(btn_shift), .btn_enter(btn_enter),
        .ser_wr_valid(ser_wr_valid), .ser_wr_addr(ser_wr_addr), .ser_wr_data(ser_wr_data),
        .ser_wr_ack(ser_wr_ack), .machine_run_enable(machine_run_enable), .serial_enable(serial_enable),
        .ready(ready), .nv_store(nv_store), .nv_addr(nv_addr), .nv_data(nv_data), .disp_kind(disp_kind),
        .disp_menu(disp_menu), .disp_code_letter(disp_code_letter), .disp_code_tens(disp_code_tens),
        .disp_code_ones(disp_code_ones), .disp_value(disp_value), .disp_cursor(disp_cursor));

    key_operator i_key_operator (.ref_clk(ref_clk), .btn_increment(btn_increment),
        .btn_decrement(btn_decrement), .btn_shift(btn_shift), .btn_enter(btn_enter));

    // one-cycle pulses caught mid-cycle, where they are settled
    always @(negedge ref_clk) begin
        if (ser_wr_ack === 1'b1) acks++;
        if (nv_store === 1'b1) begin
            stores++;
            st_addr = nv_addr;
            st_data = nv_data;
        end
    end

    // ****************
    // helpers
    // ****************
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic disp(input logic [1:0] kind, input logic [3:0] tens, input logic [3:0] ones);
        check("kind", 16'(kind), 16'(disp_kind));
        check("letter", 16'(ACCESS_LETTER), 16'(disp_code_letter));
        check("tens", 16'(tens), 16'(disp_code_tens));
        check("ones", 16'(ones), 16'(disp_code_ones));
    endtask

    task automatic push(input logic [1:0] w, input int n);
        repeat (n) i_key_operator.press(w);
    endtask

    task automatic ser_write(input logic [ADDR_W-1:0] a, input logic [VALUE_W-1:0] d);
        @(negedge ref_clk);
        {ser_wr_valid, ser_wr_addr, ser_wr_data} = {1'b1, a, d};
        @(negedge ref_clk);
        ser_wr_valid = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic print_verdict;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_run;
        push(ENT, 1);
        check("kind", 16'(SHOW_VERSION), 16'(disp_kind));
        check("ready", 16'h0001, 16'(ready));
        ser_write(7'h04, 16'h1000);
        check("acks", 16'h0001, 16'(acks));
    endtask

    task automatic t_menus;
        programming_switch_position = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("kind", 16'(SHOW_TITLE), 16'(disp_kind));
        check("status", 16'h0000, 16'({machine_run_enable, serial_enable, ready}));
        ser_write(7'h05, 16'h2222);
        check("acks", 16'h0001, 16'(acks));
        push(INC, 3);
        check("menu", 16'(MENU_TEST), 16'(disp_menu));
        push(INC, 1);
        check("menu", 16'(MENU_DATA_IN), 16'(disp_menu));
        push(DEC, 1);
        check("menu", 16'(MENU_LAST), 16'(disp_menu));
        push(INC, 1);
    endtask

    task automatic t_browse;
        push(ENT, 1);
        disp(SHOW_NAME, 4'h0, 4'h0);
        push(DEC, 1);
        disp(SHOW_NAME, 4'h3, 4'h0);
        push(INC, 5);
        disp(SHOW_NAME, 4'h0, 4'h4);
    endtask

    task automatic t_edit;
        push(ENT, 1);
        check("kind", 16'(SHOW_VALUE), 16'(disp_kind));
        check("value", 16'h1000, disp_value);
        check("cursor", 16'(CURSOR_LEFT), 16'(disp_cursor));
        push(DEC, 1);
        check("value", 16'h0000, disp_value);
        push(SHF, 1);
        push(INC, 5);
        check("value", 16'h0500, disp_value);
        push(SHF, 2);
        check("cursor", 16'(CURSOR_RIGHT), 16'(disp_cursor));
        push(DEC, 1);
        check("value", 16'h0509, disp_value);
        push(INC, 1);
        check("value", 16'h0500, disp_value);
        push(SHF, 1);
        check("cursor", 16'(CURSOR_LEFT), 16'(disp_cursor));
        push(ENT, 1);
        check("stores", 16'h0001, 16'(stores));
        check("st_addr", 16'h0004, 16'(st_addr));
        check("st_data", 16'h0500, st_data);
        disp(SHOW_NAME, 4'h0, 4'h5);
    endtask

    task automatic t_back;
        push(SHF, 1);
        check("kind", 16'(SHOW_TITLE), 16'(disp_kind));
        programming_switch_position = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("kind", 16'(SHOW_VERSION), 16'(disp_kind));
        check("ready", 16'h0001, 16'(ready));
        check("status", 16'h0007, 16'({machine_run_enable, serial_enable, ready}));
        ser_write(7'h06, 16'h0123);
        check("acks", 16'h0002, 16'(acks));
    endtask

    initial begin
        repeat (5) @(negedge ref_clk);
        reset = 1'b0;
        @(negedge ref_clk);
        t_run();
        t_menus();
        t_browse();
        t_edit();
        t_back();
        print_verdict();
    end

    initial begin
        repeat (5000) @(negedge ref_clk);
        num_errors++;
        print_verdict();
    end
endmodule // keypad_register_editor_tb
